// >>> verilog/afs_pkg.sv
// constants, types and register map of the aux function strobe handshake
// assumes one 10 MHz clock shared by the controller end and the plc end
package afs_pkg;
	localparam int N_MISC = 7;
	localparam int CODE_W = 32;
	localparam logic [CODE_W-1:0] NO_CODE = 32'hffffffff;
	typedef logic [N_MISC-1:0][CODE_W-1:0] afs_codes_t;

	// register port
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADR_MISC0 = 4'h0;
	localparam logic [ADDR_W-1:0] ADR_SPINDLE = 4'h7;
	localparam logic [ADDR_W-1:0] ADR_TOOL = 4'h8;
	localparam logic [ADDR_W-1:0] ADR_RETURN = 4'h9;
	localparam logic [ADDR_W-1:0] ADR_CONFIG = 4'ha;
	localparam logic [ADDR_W-1:0] ADR_MIN_TIME = 4'hb;
	localparam logic [ADDR_W-1:0] ADR_COMMAND = 4'hc;
	localparam logic [ADDR_W-1:0] ADR_STATUS = 4'hd;

	// config fields
	localparam int CFG_BEFORE_LSB = 0;
	localparam int CFG_AFTER_LSB = 7;
	localparam int CFG_NOWAIT_LSB = 14;
	localparam int CFG_S_CODED_BIT = 21;
	localparam int CFG_S_PRESENT_BIT = 22;
	localparam int CFG_T_PRESENT_BIT = 23;
	localparam int CFG_RETURN_BIT = 24;
	localparam logic [31:0] CONFIG_RST = 32'h00000000;
	localparam int CMD_GO_BIT = 0;

	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int MIN_TIME_UNIT_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * MIN_TIME_UNIT_US;
	localparam int MIN_TIME_W = 16;
	localparam logic [MIN_TIME_W-1:0] MIN_TIME_RST = 16'h0001;
	localparam int PRE_W = 24;

	// transfer stages of one block
	localparam logic [2:0] STG_BEFORE_WAIT = 3'h0;
	localparam logic [2:0] STG_BEFORE_TIMED = 3'h1;
	localparam logic [2:0] STG_MOVE = 3'h2;
	localparam logic [2:0] STG_AFTER_WAIT = 3'h3;
	localparam logic [2:0] STG_AFTER_TIMED = 3'h4;
	localparam logic [2:0] STG_RETURN = 3'h5;

	typedef enum logic [6:0] {
		CS_IDLE = 7'h01,
		CS_PICK = 7'h02,
		CS_RAISE = 7'h04,
		CS_WLOW = 7'h08,
		CS_WHIGH = 7'h10,
		CS_TIMED = 7'h20,
		CS_GAP = 7'h40
	} afs_cnc_state_t;

	typedef enum logic [2:0] {
		PS_IDLE = 3'h1,
		PS_BUSY = 3'h2,
		PS_DONE = 3'h4
	} afs_plc_state_t;
endpackage

// >>> verilog/afs_if.sv
// link between the controller end and the plc end
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface afs_if;
	import afs_pkg::*;
	afs_codes_t misc_code;
	logic [CODE_W-1:0] spindle_code;
	logic [CODE_W-1:0] tool_code;
	logic [CODE_W-1:0] return_code;
	logic misc_strobe;
	logic spindle_strobe;
	logic tool_strobe;
	logic return_tool_strobe;
	logic aux_done;

	modport cnc (
		output misc_code, spindle_code, tool_code, return_code,
		output misc_strobe, spindle_strobe, tool_strobe, return_tool_strobe,
		input aux_done
	);
	modport plc (
		input misc_code, spindle_code, tool_code, return_code,
		input misc_strobe, spindle_strobe, tool_strobe, return_tool_strobe,
		output aux_done
	);
endinterface

// >>> verilog/afs_plc.sv
// plc end: acknowledges strobes through aux_done after user work is done
// assumes the user side finishes each job with a one-cycle job_ack
`timescale 1ns/1ns
module afs_plc
	import afs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// link
	afs_if.plc lnk,
	// user side
	output logic job_valid,
	output logic [3:0] job_flags,
	output afs_codes_t job_misc,
	output logic [CODE_W-1:0] job_spindle,
	output logic [CODE_W-1:0] job_tool,
	output logic [CODE_W-1:0] job_return,
	input wire logic job_ack
);
	afs_plc_state_t state_reg, state_next;
	logic done_reg, done_next;
	logic [3:0] flags_reg, flags_next;
	afs_codes_t misc_reg, misc_next;
	logic [CODE_W-1:0] spindle_reg, spindle_next;
	logic [CODE_W-1:0] tool_reg, tool_next;
	logic [CODE_W-1:0] return_reg, return_next;
	logic [3:0] strobes;

	assign strobes = {lnk.return_tool_strobe, lnk.tool_strobe, lnk.spindle_strobe,
		lnk.misc_strobe};

	always_comb
	begin
		state_next = state_reg;
		done_next = done_reg;
		flags_next = flags_reg;
		misc_next = misc_reg;
		spindle_next = spindle_reg;
		tool_next = tool_reg;
		return_next = return_reg;
		unique case (state_reg)
			PS_IDLE:
			begin
				if (strobes != 4'h0)
				begin
					done_next = 1'b0;
					flags_next = strobes;
					misc_next = lnk.misc_code;
					spindle_next = lnk.spindle_code;
					tool_next = lnk.tool_code;
					return_next = lnk.return_code;
					state_next = PS_BUSY;
				end
			end
			PS_BUSY:
			begin
				if (job_ack)
				begin
					done_next = 1'b1;
					state_next = PS_DONE;
				end
			end
			PS_DONE:
			begin
				// held high until the strobes drop
				if (strobes == 4'h0)
				begin
					state_next = PS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_reg <= PS_IDLE;
			done_reg <= 1'b1;
			flags_reg <= 4'h0;
			misc_reg <= '1;
			spindle_reg <= NO_CODE;
			tool_reg <= NO_CODE;
			return_reg <= NO_CODE;
		end
		else
		begin
			state_reg <= state_next;
			done_reg <= done_next;
			flags_reg <= flags_next;
			misc_reg <= misc_next;
			spindle_reg <= spindle_next;
			tool_reg <= tool_next;
			return_reg <= return_next;
		end
	end

	assign lnk.aux_done = done_reg;
	assign job_valid = (state_reg == PS_BUSY);
	assign job_flags = flags_reg;
	assign job_misc = misc_reg;
	assign job_spindle = spindle_reg;
	assign job_tool = tool_reg;
	assign job_return = return_reg;
endmodule

// >>> verilog/afs_cnc.sv
// controller end: sequences the aux function transfers of one block
// assumes the plc end shares clk; software uses the plain register port
//
// Contract
// - load seven misc registers, then raise strobe
// - misc codes before, after movement, or both
// - per code: wait for aux_done or not
// - coded spindle: load, strobe, await aux_done
// - tool code at start, await aux_done
// - tool change: return pocket, strobe, await
// - start strobes together, one aux_done
// - code registers valid before any strobe
// - plc drops aux_done on seeing strobe
// - plc executes, then raises aux_done
// - aux_done held high beyond minimum time
// - after minimum time drop all strobes
// - minimum-time gap between consecutive transfers
// - no-wait misc strobe timed, no acknowledge
// - minimum time at least one plc scan
// - plc executes the seven misc codes
// - lowest registers first, unused all ones
// - eight bcd digits, all ones if absent
`timescale 1ns/1ns
module afs_cnc
	import afs_pkg::*;
#(
	parameter int TICK = TICK_CYCLES
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// movement handshake
	output logic move_start,
	input wire logic move_done,
	output logic block_done,
	// link
	afs_if.cnc lnk
);
	localparam logic [PRE_W-1:0] TICK_M1 = PRE_W'(TICK - 1);

	// lowest-numbered slots first, free slots all ones
	function automatic afs_codes_t pack_codes(input afs_codes_t codes,
		input logic [N_MISC-1:0] sel);
		afs_codes_t res;
		int k;
		res = '1;
		k = 0;
		for (int i = 0; i < N_MISC; i++)
		begin
			if (sel[i])
			begin
				res[k] = codes[i];
				k = k + 1;
			end
		end
		return res;
	endfunction

	// software registers
	afs_codes_t msw_reg, msw_next;
	logic [CODE_W-1:0] ssw_reg, ssw_next;
	logic [CODE_W-1:0] tsw_reg, tsw_next;
	logic [CODE_W-1:0] rsw_reg, rsw_next;
	logic [31:0] cfg_reg, cfg_next;
	logic [MIN_TIME_W-1:0] mint_reg, mint_next;
	logic go_reg, go_next;
	logic [31:0] rdata_reg, rdata_next;

	// sequencer
	afs_cnc_state_t state_reg, state_next;
	logic [2:0] stage_reg, stage_next;
	logic [PRE_W-1:0] pre_reg, pre_next;
	logic [MIN_TIME_W-1:0] ms_reg, ms_next;
	afs_codes_t mcode_reg, mcode_next;
	logic [CODE_W-1:0] scode_reg, scode_next;
	logic [CODE_W-1:0] tcode_reg, tcode_next;
	logic [CODE_W-1:0] rcode_reg, rcode_next;
	logic [3:0] strb_reg, strb_next;
	logic [3:0] want_reg, want_next;
	logic timed_reg, timed_next;
	logic move_reg, move_next;
	logic bdone_reg, bdone_next;

	logic [N_MISC-1:0] before_m, after_m, nowait_m, sel;
	logic want_s, want_t, want_r, expired;

	assign before_m = cfg_reg[CFG_BEFORE_LSB +: N_MISC];
	assign after_m = cfg_reg[CFG_AFTER_LSB +: N_MISC];
	assign nowait_m = cfg_reg[CFG_NOWAIT_LSB +: N_MISC];
	assign expired = (pre_reg == '0) && (ms_reg == '0);

	always_comb
	begin
		msw_next = msw_reg;
		ssw_next = ssw_reg;
		tsw_next = tsw_reg;
		rsw_next = rsw_reg;
		cfg_next = cfg_reg;
		mint_next = mint_reg;
		go_next = 1'b0;
		rdata_next = 32'h00000000;
		if (wr)
		begin
			if (addr < ADR_SPINDLE)
			begin
				msw_next[addr[2:0]] = wdata;
			end
			case (addr)
				ADR_SPINDLE: ssw_next = wdata;
				ADR_TOOL: tsw_next = wdata;
				ADR_RETURN: rsw_next = wdata;
				ADR_CONFIG: cfg_next = wdata;
				ADR_MIN_TIME: mint_next = wdata[MIN_TIME_W-1:0];
				ADR_COMMAND: go_next = wdata[CMD_GO_BIT];
				default: ;
			endcase
		end
		if (rd)
		begin
			if (addr < ADR_SPINDLE)
			begin
				rdata_next = msw_reg[addr[2:0]];
			end
			case (addr)
				ADR_SPINDLE: rdata_next = ssw_reg;
				ADR_TOOL: rdata_next = tsw_reg;
				ADR_RETURN: rdata_next = rsw_reg;
				ADR_CONFIG: rdata_next = cfg_reg;
				ADR_MIN_TIME: rdata_next = {16'h0000, mint_reg};
				ADR_STATUS: rdata_next = {17'h00000, strb_reg, stage_reg, state_reg,
					state_reg != CS_IDLE};
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			msw_reg <= '1;
			ssw_reg <= NO_CODE;
			tsw_reg <= NO_CODE;
			rsw_reg <= NO_CODE;
			cfg_reg <= CONFIG_RST;
			mint_reg <= MIN_TIME_RST;
			go_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end
		else
		begin
			msw_reg <= msw_next;
			ssw_reg <= ssw_next;
			tsw_reg <= tsw_next;
			rsw_reg <= rsw_next;
			cfg_reg <= cfg_next;
			mint_reg <= mint_next;
			go_reg <= go_next;
			rdata_reg <= rdata_next;
		end
	end

	// content of the current stage
	always_comb
	begin
		sel = '0;
		want_s = 1'b0;
		want_t = 1'b0;
		want_r = 1'b0;
		case (stage_reg)
			STG_BEFORE_WAIT:
			begin
				sel = before_m & ~nowait_m;
				want_s = cfg_reg[CFG_S_PRESENT_BIT] & cfg_reg[CFG_S_CODED_BIT];
				want_t = cfg_reg[CFG_T_PRESENT_BIT];
			end
			STG_BEFORE_TIMED: sel = before_m & nowait_m;
			STG_AFTER_WAIT: sel = after_m & ~nowait_m;
			STG_AFTER_TIMED: sel = after_m & nowait_m;
			STG_RETURN: want_r = cfg_reg[CFG_RETURN_BIT];
			default: ;
		endcase
	end

	always_comb
	begin
		state_next = state_reg;
		stage_next = stage_reg;
		mcode_next = mcode_reg;
		scode_next = scode_reg;
		tcode_next = tcode_reg;
		rcode_next = rcode_reg;
		strb_next = strb_reg;
		want_next = want_reg;
		timed_next = timed_reg;
		move_next = 1'b0;
		bdone_next = 1'b0;
		// interval counter on clk
		pre_next = pre_reg;
		ms_next = ms_reg;
		if (pre_reg != '0)
		begin
			pre_next = pre_reg - 1'b1;
		end
		else if (ms_reg != '0)
		begin
			pre_next = TICK_M1;
			ms_next = ms_reg - 1'b1;
		end
		unique case (state_reg)
			CS_IDLE:
			begin
				if (go_reg)
				begin
					// no code of an earlier block leaks into this one
					scode_next = NO_CODE;
					tcode_next = NO_CODE;
					rcode_next = NO_CODE;
					stage_next = STG_BEFORE_WAIT;
					state_next = CS_PICK;
				end
			end
			CS_PICK:
			begin
				if (stage_reg > STG_RETURN)
				begin
					bdone_next = 1'b1;
					state_next = CS_IDLE;
				end
				else if (stage_reg == STG_MOVE)
				begin
					move_next = !move_reg && !timed_reg;
					timed_next = 1'b1;
					if (move_done && timed_reg)
					begin
						timed_next = 1'b0;
						stage_next = stage_reg + 3'h1;
					end
				end
				else if ((sel != '0) || want_s || want_t || want_r)
				begin
					// codes first, strobes one cycle later
					mcode_next = pack_codes(msw_reg, sel);
					if (stage_reg == STG_BEFORE_WAIT)
					begin
						scode_next = want_s ? ssw_reg : NO_CODE;
						tcode_next = want_t ? tsw_reg : NO_CODE;
					end
					if (want_r)
					begin
						rcode_next = rsw_reg;
					end
					want_next = {want_r, want_t, want_s, sel != '0};
					timed_next = (stage_reg == STG_BEFORE_TIMED) ||
						(stage_reg == STG_AFTER_TIMED);
					state_next = CS_RAISE;
				end
				else
				begin
					stage_next = stage_reg + 3'h1;
				end
			end
			CS_RAISE:
			begin
				strb_next = want_reg;
				pre_next = TICK_M1;
				ms_next = mint_reg;
				state_next = timed_reg ? CS_TIMED : CS_WLOW;
			end
			CS_WLOW:
			begin
				// aux_done looked at only while strobes stand
				if (!lnk.aux_done)
				begin
					state_next = CS_WHIGH;
				end
			end
			CS_WHIGH:
			begin
				if (!lnk.aux_done)
				begin
					pre_next = TICK_M1;
					ms_next = mint_reg;
				end
				else if (expired)
				begin
					strb_next = 4'h0;
					pre_next = TICK_M1;
					ms_next = mint_reg;
					state_next = CS_GAP;
				end
			end
			CS_TIMED:
			begin
				if (expired)
				begin
					strb_next = 4'h0;
					timed_next = 1'b0;
					pre_next = TICK_M1;
					ms_next = mint_reg;
					state_next = CS_GAP;
				end
			end
			CS_GAP:
			begin
				if (expired)
				begin
					stage_next = stage_reg + 3'h1;
					state_next = CS_PICK;
				end
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_reg <= CS_IDLE;
			stage_reg <= STG_BEFORE_WAIT;
			pre_reg <= '0;
			ms_reg <= '0;
			mcode_reg <= '1;
			scode_reg <= NO_CODE;
			tcode_reg <= NO_CODE;
			rcode_reg <= NO_CODE;
			strb_reg <= 4'h0;
			want_reg <= 4'h0;
			timed_reg <= 1'b0;
			move_reg <= 1'b0;
			bdone_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			stage_reg <= stage_next;
			pre_reg <= pre_next;
			ms_reg <= ms_next;
			mcode_reg <= mcode_next;
			scode_reg <= scode_next;
			tcode_reg <= tcode_next;
			rcode_reg <= rcode_next;
			strb_reg <= strb_next;
			want_reg <= want_next;
			timed_reg <= timed_next;
			move_reg <= move_next;
			bdone_reg <= bdone_next;
		end
	end

	assign rdata = rdata_reg;
	assign move_start = move_reg;
	assign block_done = bdone_reg;
	assign lnk.misc_code = mcode_reg;
	assign lnk.spindle_code = scode_reg;
	assign lnk.tool_code = tcode_reg;
	assign lnk.return_code = rcode_reg;
	assign lnk.misc_strobe = strb_reg[0];
	assign lnk.spindle_strobe = strb_reg[1];
	assign lnk.tool_strobe = strb_reg[2];
	assign lnk.return_tool_strobe = strb_reg[3];
endmodule

// >>> verif/afs_chk.sv
// checker for the aux function strobe link
// assumes one clock; TICK and MIN_UNITS match the min time in use
`timescale 1ns/1ns
module afs_chk
	import afs_pkg::*;
#(
	parameter int TICK = 4,
	parameter int MIN_UNITS = 1
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// link
	input wire afs_codes_t misc_code,
	input wire logic [CODE_W-1:0] spindle_code,
	input wire logic [CODE_W-1:0] tool_code,
	input wire logic [CODE_W-1:0] return_code,
	input wire logic misc_strobe,
	input wire logic spindle_strobe,
	input wire logic tool_strobe,
	input wire logic return_tool_strobe,
	input wire logic aux_done
);
	localparam int MIN_CYC = TICK * MIN_UNITS;
	logic any_s;
	logic ok_pack;
	logic [7:0] hi_reg, hi_next, lo_reg, lo_next;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	always_comb
	begin
		any_s = misc_strobe | spindle_strobe | tool_strobe | return_tool_strobe;
		hi_next = aux_done ? hi_reg + {7'h00, hi_reg != 8'hff} : 8'h00;
		lo_next = any_s ? 8'h00 : lo_reg + {7'h00, lo_reg != 8'hff};
		ok_pack = 1'b1;
		for (int i = 1; i < N_MISC; i++)
			if (misc_code[i-1] == NO_CODE && misc_code[i] != NO_CODE)
				ok_pack = 1'b0;
	end
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			hi_reg <= 8'h00;
			lo_reg <= 8'hff;
		end
		else
		begin
			hi_reg <= hi_next;
			lo_reg <= lo_next;
		end
	end
	property p_reset_quiet;
		$rose(rstn) |-> !any_s;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("strobe after reset");
	property p_codes_valid;
		any_s |-> $stable(misc_code) && $stable(spindle_code)
			&& $stable(tool_code) && $stable(return_code);
	endproperty
	a_codes_valid: assert property (p_codes_valid) else $error("code moved");
	property p_misc_packed;
		misc_strobe |-> ok_pack;
	endproperty
	a_misc_packed: assert property (p_misc_packed) else $error("misc gap");
	property p_hold_min;
		$fell(tool_strobe) || $fell(spindle_strobe) || $fell(return_tool_strobe)
			|-> hi_reg >= MIN_CYC;
	endproperty
	a_hold_min: assert property (p_hold_min) else $error("done too short");
	property p_drop_bound;
		$rose(aux_done) && any_s |-> ##[1:40] !any_s;
	endproperty
	a_drop_bound: assert property (p_drop_bound) else $error("strobes stuck");
	property p_gap;
		$rose(any_s) |-> lo_reg >= MIN_CYC;
	endproperty
	a_gap: assert property (p_gap) else $error("gap too short");
	// 4 is TICK times MIN_UNITS as used by the bench
	property p_timed_len;
		$rose(misc_strobe) |-> misc_strobe [*4];
	endproperty
	a_timed_len: assert property (p_timed_len) else $error("misc strobe short");
	property p_plc_start;
		$rose(any_s) |=> !aux_done;
	endproperty
	a_plc_start: assert property (p_plc_start) else $error("no start mark");
endmodule

// >>> verif/afs_bench.sv
// self-checking bench: controller end and plc end joined by the link
// assumes TICK 4 and min time 1; bench plays software, movement and plc user
`timescale 1ns/1ns
module afs_bench
	import afs_pkg::*;
;
	typedef struct {
		logic mv;
		logic [3:0] fl;
		afs_codes_t mc;
		logic [31:0] sp, tl, rt;
	} afs_job_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [ADDR_W-1:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic move_done = 1'b0;
	logic job_ack = 1'b0;
	logic [31:0] rdata, cfg;
	logic move_start, block_done, job_valid;
	logic [3:0] job_flags;
	afs_codes_t job_misc;
	logic [31:0] job_spindle, job_tool, job_return;
	logic [31:0] code [10];
	int fails = 0;
	int num_checks = 0;
	int seed = 32'heb6c;
	afs_job_t exp_q [$];
	afs_if lnk();
	afs_cnc #(.TICK(4)) afs_cnc_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .move_start(move_start), .move_done(move_done),
		.block_done(block_done), .lnk(lnk.cnc));
	afs_plc afs_plc_inst (.clk(clk), .rstn(rstn), .lnk(lnk.plc), .job_valid(job_valid),
		.job_flags(job_flags), .job_misc(job_misc), .job_spindle(job_spindle),
		.job_tool(job_tool), .job_return(job_return), .job_ack(job_ack));
	afs_chk #(.TICK(4), .MIN_UNITS(1)) afs_chk_inst (.clk(clk), .rstn(rstn),
		.misc_code(lnk.misc_code), .spindle_code(lnk.spindle_code),
		.tool_code(lnk.tool_code), .return_code(lnk.return_code),
		.misc_strobe(lnk.misc_strobe), .spindle_strobe(lnk.spindle_strobe),
		.tool_strobe(lnk.tool_strobe), .return_tool_strobe(lnk.return_tool_strobe),
		.aux_done(lnk.aux_done));
	always #50 clk = ~clk;
	task check(input logic [223:0] seen, input logic [223:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task wreg(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task rreg(input logic [3:0] a, output logic [31:0] q);
		addr <= a;
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		q = rdata;
	endtask
	// expected misc slots: selected codes lowest first, rest all ones
	function automatic afs_codes_t pack(input logic [6:0] m);
		afs_codes_t r;
		int k;
		r = {N_MISC{NO_CODE}};
		k = 0;
		for (int i = 0; i < N_MISC; i++)
			if (m[i])
			begin
				r[k] = code[i];
				k++;
			end
		return r;
	endfunction
	task push(input logic mv, input logic [3:0] fl, input logic [6:0] m);
		afs_job_t j;
		j.mv = mv;
		j.fl = fl;
		j.mc = pack(m);
		j.sp = (cfg[21] & cfg[22]) ? code[7] : NO_CODE;
		j.tl = cfg[23] ? code[8] : NO_CODE;
		j.rt = fl[3] ? code[9] : NO_CODE;
		if (mv || fl != 4'h0)
			exp_q.push_back(j);
	endtask
	// plc user and movement responder
	initial
	begin
		afs_job_t j;
		logic mv;
		forever
		begin
			@(posedge clk);
			if (job_valid === 1'b1 || move_start === 1'b1)
			begin
				mv = move_start;
				check(exp_q.size() > 0, 1'b1);
				if (exp_q.size() > 0)
				begin
					j = exp_q.pop_front();
					check(move_start, j.mv);
					if (!j.mv)
						check(job_flags, j.fl);
					if (!j.mv && j.fl[0])
						check(job_misc, j.mc);
					if (!j.mv && (j.fl[1] | j.fl[2]))
						check({job_spindle, job_tool}, {j.sp, j.tl});
					if (!j.mv)
						check(job_return, j.rt);
				end
				repeat ($unsigned($random(seed)) % 4) @(posedge clk);
				move_done <= mv;
				job_ack <= !mv;
				@(posedge clk);
				move_done <= 1'b0;
				job_ack <= 1'b0;
			end
		end
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		fails++;
		print_verdict();
	end
	initial
	begin
		logic [31:0] q;
		logic [6:0] bw, bt, aw, at;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		check(lnk.tool_code, NO_CODE);
		check({lnk.misc_strobe, lnk.spindle_strobe, lnk.tool_strobe,
			lnk.return_tool_strobe}, 4'h0);
		rreg(ADR_CONFIG, q);
		check(q, CONFIG_RST);
		wreg(ADR_MIN_TIME, 32'habcd0001);
		wreg(4'he, 32'h5);
		rreg(ADR_MIN_TIME, q);
		check(q, 32'h00000001);
		rreg(4'he, q);
		check(q, 32'h0);
		for (int b = 0; b < 16; b++)
		begin
			cfg = (b == 0) ? 32'h01e03fff : (b == 1) ? 32'h01ffffff
				: $random(seed) & 32'h01ffffff;
			for (int i = 0; i < 10; i++)
			begin
				code[i] = $random(seed);
				wreg(i[3:0], code[i]);
			end
			wreg(ADR_CONFIG, cfg);
			rreg(ADR_CONFIG, q);
			check(q, cfg);
			bw = cfg[6:0] & ~cfg[20:14];
			bt = cfg[6:0] & cfg[20:14];
			aw = cfg[13:7] & ~cfg[20:14];
			at = cfg[13:7] & cfg[20:14];
			push(1'b0, {1'b0, cfg[23], cfg[21] & cfg[22], |bw}, bw);
			push(1'b0, {3'h0, |bt}, bt);
			push(1'b1, 4'h0, 7'h0);
			push(1'b0, {3'h0, |aw}, aw);
			push(1'b0, {3'h0, |at}, at);
			push(1'b0, {cfg[24], 3'h0}, 7'h0);
			wreg(ADR_COMMAND, 32'h1);
			wr <= 1'b0;
			repeat (4) @(posedge clk);
			wreg(ADR_COMMAND, 32'h1);
			wr <= 1'b0;
			for (int n = 0; n < 2000 && block_done !== 1'b1; n++)
				@(posedge clk);
			check(block_done, 1'b1);
			check(exp_q.size() == 0, 1'b1);
			rreg(ADR_STATUS, q);
			check({q[14:11], q[7:0]}, 12'h002);
		end
		print_verdict();
	end
endmodule
